// ==== logic/sar_seq_pkg.sv ====
// Constants, types and register map of the converter sequencer control.
// Assumes a single 50 MHz clock domain and an AXI4-Lite register master.
package sar_seq_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NUM_PIN = 8;
  localparam int NUM_CH = 9;
  localparam int TEMP_CH = 8;
  localparam int DATA_W = 12;
  localparam int CH_W = 4;
  localparam int ST_W = 8;
  localparam int ADDR_W = 8;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam longint CLK_HZ = 50_000_000;
  localparam longint SAR_MAX_HZ = 14_500_000;
  localparam int SAR_DIV = int'((CLK_HZ + SAR_MAX_HZ - 1) / SAR_MAX_HZ);
  localparam int CONV_CLKS = 18;
  localparam int SAMPLE_MIN = 2;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] CMD_OFF = 8'h04;
  localparam logic [7:0] CHAN_EN_OFF = 8'h08;
  localparam logic [7:0] LIMIT_LOW_OFF = 8'h0c;
  localparam logic [7:0] LIMIT_HIGH_OFF = 8'h10;
  localparam logic [7:0] INTR_OFF = 8'h14;
  localparam logic [7:0] MASK_OFF = 8'h18;
  localparam logic [7:0] STATUS_OFF = 8'h1c;
  localparam logic [1:0] SAMPLE_PAGE = 2'h1;
  localparam logic [1:0] RESULT_PAGE = 2'h2;

  // ----------------------------------------------------------------
  // Reset values and fields
  // ----------------------------------------------------------------
  localparam logic [8:0] CTRL_RST = 9'h000;
  localparam logic [8:0] CHAN_EN_RST = 9'h001;
  localparam logic [11:0] LIMIT_LOW_RST = 12'h000;
  localparam logic [11:0] LIMIT_HIGH_RST = 12'hfff;
  localparam logic [7:0] SAMPLE_RST = 8'h00;
  localparam int INTR_RANGE = 0;
  localparam int INTR_DONE = 1;
  localparam int INTR_W = 2;
  localparam int RES_RANGE_BIT = 15;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {REF_VDD, REF_VDD_HALF, REF_INTERNAL, REF_EXTERNAL} ref_t;

  typedef struct packed {
    logic [3:0] fw_chan;
    ref_t ref_sel;
    logic continuous;
    logic fw_mode;
    logic enable;
  } ctrl_t;

endpackage

// ==== logic/sar_seq_ctrl.sv ====
// Sequencer, timing and register file around a 12-bit SAR converter core.
// Assumes the core samples while sample is high, converts on sar_clk while
// convert is high and presents core_data in aclk domain when convert ends.
`timescale 1ns/100ps

// How it works
// - Eight pin channels reach the converter through one channel select driven by the sequencer.
// - In scan mode the sequencer walks the enabled channels by itself.
// - A new channel starts sampling at the very edge where the previous conversion ends.
// - A control bit picks state machine scanning or firmware chosen channels.
// - Every channel keeps its own result word.
// - Every channel has its own sample time applied whenever it is converted.
// - Each result outside the low and high limits raises the out-of-range interrupt.
// - The limit check is made on each result as it is stored.
// - The converter clock stays under 14.5 MHz and a conversion lasts 18 of its clocks.
// - The sample aperture length is programmable so slow drivers may settle.
// - A field selects supply, half supply, internal or external reference.
// - The temperature sensor is a ninth convertible channel.
// - In deep low power the sequencer and converter clock stop.
module sar_seq_ctrl
  import sar_seq_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Converter core
  output logic [CH_W-1:0] mux_sel,
  output logic sample,
  output logic convert,
  output logic sar_clk,
  output ref_t ref_sel,
  input wire logic [DATA_W-1:0] core_data,
  // Power and interrupt
  input wire logic lp_deep,
  output logic irq
);

  typedef enum logic [1:0] {S_IDLE, S_SAMPLE, S_CONVERT} state_t;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic awready_reg, awready_next, wready_reg, wready_next, bvalid_reg, bvalid_next;
  logic arready_reg, arready_next, rvalid_reg, rvalid_next;
  logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic [31:0] rdata_reg, rdata_next, wdata_reg, wdata_next;
  logic [ADDR_W-1:0] awaddr_reg, awaddr_next;
  logic have_aw_reg, have_aw_next, have_w_reg, have_w_next;
  ctrl_t ctrl_reg, ctrl_next;
  logic start_reg, start_next;
  logic [NUM_CH-1:0] chan_en_reg, chan_en_next;
  logic [DATA_W-1:0] low_reg, low_next, high_reg, high_next;
  logic [INTR_W-1:0] intr_reg, intr_next, mask_reg, mask_next, clr_w;
  logic [ST_W-1:0] samp_reg [NUM_CH], samp_next [NUM_CH];
  logic irq_reg, irq_next;
  logic lp_meta_reg, lp_sync_reg;
  state_t state_reg, state_next;
  logic [CH_W-1:0] ch_reg, ch_next;
  logic [8:0] cnt_reg, cnt_next;
  logic pend_reg, pend_next, sample_reg, sample_next, convert_reg, convert_next;
  logic [3:0] div_reg, div_next;
  logic sar_clk_reg, sar_clk_next;
  logic [DATA_W:0] result_mem [NUM_CH], result_next [NUM_CH];
  logic tick, ev_result, ev_range, ev_done, out_range;
  logic [ST_W-1:0] cur_samp;
  logic [CH_W:0] nxt;

  // Elaboration check of divider and channel count
  if (SAR_DIV < 2 || SAR_DIV > 15 || NUM_CH > 15) begin : g_bad_cfg
    $error("sar_seq_ctrl: unsupported divider or channel count");
  end

  // Lowest enabled channel at or above a start index
  function automatic logic [CH_W:0] next_en(input logic [NUM_CH-1:0] en, input int from);
    logic [CH_W:0] r;
    r = '0;
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      if (en[i] && i >= from) begin
        r = {1'b1, CH_W'(i)};
      end
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Low power request synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lp_meta_reg <= 1'b0;
      lp_sync_reg <= 1'b0;
    end else begin
      lp_meta_reg <= lp_deep;
      lp_sync_reg <= lp_meta_reg;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer and converter timing
  // ----------------------------------------------------------------
  assign tick = (div_reg == 4'(SAR_DIV - 1));
  assign cur_samp = samp_reg[ch_reg];
  assign out_range = (core_data < low_reg) || (core_data > high_reg);

  // Next sequencer state, converter clock and result buffers
  always_comb begin
    state_next = state_reg;
    ch_next = ch_reg;
    cnt_next = cnt_reg;
    pend_next = pend_reg | start_reg;
    sample_next = sample_reg;
    convert_next = convert_reg;
    result_next = result_mem;
    ev_result = 1'b0;
    ev_range = 1'b0;
    ev_done = 1'b0;
    nxt = '0;
    // Divider keeps the converter clock at or below its limit
    div_next = tick ? 4'h0 : div_reg + 4'h1;
    sar_clk_next = (div_next < 4'(SAR_DIV / 2));
    unique case (state_reg)
      S_IDLE: begin
        if (tick && pend_reg) begin
          pend_next = start_reg;
          if (ctrl_reg.fw_mode) begin
            nxt = {ctrl_reg.fw_chan < CH_W'(NUM_CH), ctrl_reg.fw_chan};
          end else begin
            nxt = next_en(chan_en_reg, 0);
          end
          if (nxt[CH_W]) begin
            state_next = S_SAMPLE;
            ch_next = nxt[CH_W-1:0];
            sample_next = 1'b1;
            cnt_next = '0;
          end
        end
      end
      S_SAMPLE: begin
        if (tick) begin
          // Per-channel aperture sets the track time
          if (cnt_reg == 9'(cur_samp) + 9'(SAMPLE_MIN - 1)) begin
            state_next = S_CONVERT;
            sample_next = 1'b0;
            convert_next = 1'b1;
            cnt_next = '0;
          end else begin
            cnt_next = cnt_reg + 9'h1;
          end
        end
      end
      S_CONVERT: begin
        if (tick) begin
          cnt_next = cnt_reg + 9'h1;
          if (cnt_reg == 9'(CONV_CLKS - 1)) begin
            ev_result = 1'b1;
            ev_range = out_range;
            result_next[ch_reg] = {out_range, core_data};
            convert_next = 1'b0;
            state_next = S_IDLE;
            if (!ctrl_reg.fw_mode) begin
              nxt = next_en(chan_en_reg, int'(ch_reg) + 1);
              if (!nxt[CH_W]) begin
                ev_done = 1'b1;
                if (ctrl_reg.continuous) begin
                  nxt = next_en(chan_en_reg, 0);
                end
              end
            end else begin
              ev_done = 1'b1;
              if (pend_next) begin
                nxt = {ctrl_reg.fw_chan < CH_W'(NUM_CH), ctrl_reg.fw_chan};
                pend_next = 1'b0;
              end
            end
            // Next channel tracks at once, no dead cycle
            if (nxt[CH_W]) begin
              state_next = S_SAMPLE;
              ch_next = nxt[CH_W-1:0];
              sample_next = 1'b1;
              cnt_next = '0;
            end
          end
        end
      end
    endcase
    // Disable or deep low power stops everything
    if (lp_sync_reg || !ctrl_reg.enable) begin
      state_next = S_IDLE;
      sample_next = 1'b0;
      convert_next = 1'b0;
      pend_next = 1'b0;
      cnt_next = '0;
      div_next = '0;
      sar_clk_next = 1'b0;
    end
  end

  // Sequencer registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= S_IDLE;
      ch_reg <= '0;
      cnt_reg <= '0;
      pend_reg <= 1'b0;
      sample_reg <= 1'b0;
      convert_reg <= 1'b0;
      div_reg <= '0;
      sar_clk_reg <= 1'b0;
      for (int i = 0; i < NUM_CH; i++) begin
        result_mem[i] <= '0;
      end
    end else begin
      state_reg <= state_next;
      ch_reg <= ch_next;
      cnt_reg <= cnt_next;
      pend_reg <= pend_next;
      sample_reg <= sample_next;
      convert_reg <= convert_next;
      div_reg <= div_next;
      sar_clk_reg <= sar_clk_next;
      result_mem <= result_next;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite slave and registers
  // ----------------------------------------------------------------
  // Bus handshakes, register writes and read data
  always_comb begin
    logic [ADDR_W-1:0] a;
    logic hit;
    a = '0;
    hit = 1'b0;
    clr_w = '0;
    awaddr_next = awaddr_reg;
    wdata_next = wdata_reg;
    have_aw_next = have_aw_reg | (s_axi_awvalid & awready_reg);
    have_w_next = have_w_reg | (s_axi_wvalid & wready_reg);
    if (s_axi_awvalid && awready_reg) begin
      awaddr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_reg) begin
      wdata_next = s_axi_wdata;
    end
    bvalid_next = bvalid_reg & ~s_axi_bready;
    bresp_next = bresp_reg;
    ctrl_next = ctrl_reg;
    start_next = 1'b0;
    chan_en_next = chan_en_reg;
    low_next = low_reg;
    high_next = high_reg;
    mask_next = mask_reg;
    samp_next = samp_reg;
    // Write once both address and data are held
    if (have_aw_next && have_w_next && !bvalid_reg) begin
      a = awaddr_next;
      hit = 1'b1;
      have_aw_next = 1'b0;
      have_w_next = 1'b0;
      bvalid_next = 1'b1;
      if (s_axi_wstrb != 4'h0) begin
        unique case (a)
          CTRL_OFF: ctrl_next = ctrl_t'(wdata_next[8:0]);
          CMD_OFF: start_next = wdata_next[0];
          CHAN_EN_OFF: chan_en_next = wdata_next[NUM_CH-1:0];
          LIMIT_LOW_OFF: low_next = wdata_next[DATA_W-1:0];
          LIMIT_HIGH_OFF: high_next = wdata_next[DATA_W-1:0];
          MASK_OFF: mask_next = wdata_next[INTR_W-1:0];
          INTR_OFF: clr_w = wdata_next[INTR_W-1:0];
          STATUS_OFF: hit = 1'b1;
          default: begin
            hit = (a[7:6] == RESULT_PAGE) && (a[5:2] < 4'(NUM_CH));
            if (a[7:6] == SAMPLE_PAGE && a[5:2] < 4'(NUM_CH)) begin
              samp_next[a[5:2]] = wdata_next[ST_W-1:0];
              hit = 1'b1;
            end
          end
        endcase
      end
      bresp_next = hit ? RESP_OKAY : RESP_SLVERR;
    end
    awready_next = ~have_aw_next & ~bvalid_next;
    wready_next = ~have_w_next & ~bvalid_next;
    // Sticky events, a set in the clearing cycle wins
    intr_next = (intr_reg & ~clr_w) | {ev_done, ev_range};
    irq_next = |(intr_next & mask_next);
    // Read path
    rvalid_next = rvalid_reg & ~s_axi_rready;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    if (s_axi_arvalid && arready_reg) begin
      rvalid_next = 1'b1;
      rresp_next = RESP_OKAY;
      rdata_next = '0;
      unique case (s_axi_araddr)
        CTRL_OFF: rdata_next[8:0] = ctrl_reg;
        CMD_OFF: rdata_next[0] = pend_reg;
        CHAN_EN_OFF: rdata_next[NUM_CH-1:0] = chan_en_reg;
        LIMIT_LOW_OFF: rdata_next[DATA_W-1:0] = low_reg;
        LIMIT_HIGH_OFF: rdata_next[DATA_W-1:0] = high_reg;
        INTR_OFF: rdata_next[INTR_W-1:0] = intr_reg;
        MASK_OFF: rdata_next[INTR_W-1:0] = mask_reg;
        STATUS_OFF: rdata_next[5:0] = {lp_sync_reg, ch_reg, state_reg != S_IDLE};
        default: begin
          if (s_axi_araddr[5:2] >= 4'(NUM_CH)) begin
            rresp_next = RESP_SLVERR;
          end else if (s_axi_araddr[7:6] == SAMPLE_PAGE) begin
            rdata_next[ST_W-1:0] = samp_reg[s_axi_araddr[5:2]];
          end else if (s_axi_araddr[7:6] == RESULT_PAGE) begin
            rdata_next[DATA_W-1:0] = result_mem[s_axi_araddr[5:2]][DATA_W-1:0];
            rdata_next[RES_RANGE_BIT] = result_mem[s_axi_araddr[5:2]][DATA_W];
          end else begin
            rresp_next = RESP_SLVERR;
          end
        end
      endcase
    end
    arready_next = ~rvalid_next;
  end

  // Bus and register flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_reg <= 1'b1;
      wready_reg <= 1'b1;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rresp_reg <= RESP_OKAY;
      rdata_reg <= '0;
      wdata_reg <= '0;
      awaddr_reg <= '0;
      have_aw_reg <= 1'b0;
      have_w_reg <= 1'b0;
      ctrl_reg <= ctrl_t'(CTRL_RST);
      start_reg <= 1'b0;
      chan_en_reg <= CHAN_EN_RST;
      low_reg <= LIMIT_LOW_RST;
      high_reg <= LIMIT_HIGH_RST;
      intr_reg <= '0;
      mask_reg <= '0;
      irq_reg <= 1'b0;
      for (int i = 0; i < NUM_CH; i++) begin
        samp_reg[i] <= SAMPLE_RST;
      end
    end else begin
      awready_reg <= awready_next;
      wready_reg <= wready_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      arready_reg <= arready_next;
      rvalid_reg <= rvalid_next;
      rresp_reg <= rresp_next;
      rdata_reg <= rdata_next;
      wdata_reg <= wdata_next;
      awaddr_reg <= awaddr_next;
      have_aw_reg <= have_aw_next;
      have_w_reg <= have_w_next;
      ctrl_reg <= ctrl_next;
      start_reg <= start_next;
      chan_en_reg <= chan_en_next;
      low_reg <= low_next;
      high_reg <= high_next;
      intr_reg <= intr_next;
      mask_reg <= mask_next;
      irq_reg <= irq_next;
      samp_reg <= samp_next;
    end
  end

  // Outputs straight from flops
  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp = rresp_reg;
  assign s_axi_rdata = rdata_reg;
  assign mux_sel = ch_reg;
  assign sample = sample_reg;
  assign convert = convert_reg;
  assign sar_clk = sar_clk_reg;
  assign ref_sel = ctrl_reg.ref_sel;
  assign irq = irq_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  logic [15:0] samp_cyc_hlp, conv_cyc_hlp;

  // Cycle counts of the current track and convert phases
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      samp_cyc_hlp <= '0;
      conv_cyc_hlp <= '0;
    end else begin
      samp_cyc_hlp <= sample_reg ? samp_cyc_hlp + 16'h1 : 16'h0;
      conv_cyc_hlp <= convert_reg ? conv_cyc_hlp + 16'h1 : 16'h0;
    end
  end

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence tick_gap;
    // A stop in the gap clears the divider, so the fourth tick may not come
    !tick [*3] ##1 (tick || lp_sync_reg || !ctrl_reg.enable);
  endsequence

  a_clk_div_rate: assert property (tick && !lp_sync_reg && ctrl_reg.enable |=> tick_gap)
    else $error("converter clock tick spacing wrong");
  a_conv_length: assert property ($fell(convert_reg) && $past(ev_result) |->
      conv_cyc_hlp == 16'(CONV_CLKS * SAR_DIV))
    else $error("conversion length wrong");
  a_sample_length: assert property ($fell(sample_reg) && convert_reg |->
      samp_cyc_hlp == 16'((int'($past(cur_samp)) + SAMPLE_MIN) * SAR_DIV))
    else $error("sample time wrong");
  a_zero_gap: assert property ($fell(convert_reg) && $past(ev_result) && state_reg != S_IDLE |->
      sample_reg && samp_cyc_hlp == 16'h0)
    else $error("gap between channels");
  a_result_store: assert property (ev_result |=>
      result_mem[$past(ch_reg)][DATA_W-1:0] == $past(core_data))
    else $error("result not stored");
  a_range_irq: assert property (ev_result && out_range |=> intr_reg[INTR_RANGE])
    else $error("range status not set");
  a_range_sticky: assert property (intr_reg[INTR_RANGE] && !clr_w[INTR_RANGE] |=>
      intr_reg[INTR_RANGE])
    else $error("range status lost");
  a_fw_channel: assert property ($rose(sample_reg) && $past(ctrl_reg.fw_mode) && ctrl_reg.fw_mode |->
      ch_reg == $past(ctrl_reg.fw_chan))
    else $error("firmware channel not used");
  a_low_power: assert property (lp_sync_reg |=> state_reg == S_IDLE && !sample_reg && !sar_clk_reg)
    else $error("active in low power");

endmodule

// ==== testbench/sar_core_model.sv ====
// Stand-in for the converter core and its analog inputs.
// Assumes the sequencer holds convert high for a whole conversion.
`timescale 1ns/100ps
module sar_core_model
  import sar_seq_pkg::*;
(
  // Clock
  input wire logic aclk,
  // Sequencer side
  input wire logic [CH_W-1:0] mux_sel,
  input wire logic convert,
  // Result
  output logic [DATA_W-1:0] core_data
);
  // ----------------------------------------------------------------
  // Code per channel
  // ----------------------------------------------------------------
  initial core_data = 12'h000;
  // Code held through the conversion, scrambled outside it
  always @(posedge aclk) begin
    if (convert) begin
      core_data <= 12'(mux_sel * 12'h1c3 + 12'h011);
    end else begin
      core_data <= ~core_data;
    end
  end
endmodule

// ==== testbench/sar_seq_ctrl_tb_top.sv ====
// Self-checking bench for the converter sequencer control.
// Assumes a 50 MHz clock and a register master on AXI4-Lite.
`timescale 1ns/100ps
module sar_seq_ctrl_tb_top
  import sar_seq_pkg::*;
;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic aclk = 1'b0, aresetn = 1'b0, lp_deep = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, d;
  logic [3:0] mux_sel, mux_q;
  logic sample, convert, sar_clk, irq, mon = 1'b0, sq, any;
  ref_t ref_sel;
  logic [11:0] core_data, lo, hi;
  logic [8:0] en;
  logic [7:0] st [9];
  logic [1:0] r;
  int err_count = 0, checks = 0, seed = 43, scnt = 0, ccnt = 0, pcnt = 0, n;
  int seq[$];
  logic gapq[$];

  sar_seq_ctrl i_sar_seq_ctrl (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .mux_sel, .sample, .convert, .sar_clk, .ref_sel, .core_data,
    .lp_deep, .irq);
  sar_core_model i_sar_core_model (.aclk, .mux_sel, .convert, .core_data);

  // Clock
  initial forever #10 aclk = ~aclk;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] res(int ch);
    logic [11:0] c;
    c = 12'(ch * 12'h1c3 + 12'h011);
    return {16'h0, (c < lo) || (c > hi), 3'h0, c};
  endfunction

  task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
    checks++;
    if (s !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic rpt(int k);
    repeat (k) @(posedge aclk);
  endtask

  // Write: address and data offered together, each released when taken
  task automatic wr(logic [7:0] a, logic [31:0] v, output logic [1:0] rs);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    fork
      begin do @(posedge aclk); while (!s_axi_awready); s_axi_awvalid <= 1'b0; end
      begin do @(posedge aclk); while (!s_axi_wready); s_axi_wvalid <= 1'b0; end
    join
    do @(posedge aclk); while (!s_axi_bvalid);
    rs = s_axi_bresp;
  endtask

  task automatic rd(logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    v = s_axi_rdata;
    rs = s_axi_rresp;
  endtask

  task automatic rchk(logic [7:0] a, logic [31:0] e);
    logic [31:0] v;
    logic [1:0] rs;
    rd(a, v, rs);
    chk("reg", e, v);
  endtask

  task automatic wirq;
    int k;
    k = 0;
    while (!irq && k < 4000) begin @(posedge aclk); k++; end
    // Let the monitor log the last conversion first
    @(posedge aclk);
    chk("irq_done", 32'h1, 32'(irq));
  endtask

  task automatic summarize;
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // Watchdog
  initial begin
    rpt(60000);
    err_count++;
    summarize;
  end

  // Monitor of track, conversion and converter clock lengths
  always @(posedge aclk) begin
    if (!mon) begin
      scnt = 0;
      ccnt = 0;
      pcnt = 0;
    end else begin
      pcnt++;
      if (sar_clk && !sq) begin
        if (convert && pcnt < 20) chk("sarclk", SAR_DIV, pcnt);
        pcnt = 0;
      end
      if (sample) scnt++;
      else if (scnt != 0) begin
        chk("track", (st[mux_q] + 2) * 4, scnt);
        scnt = 0;
      end
      if (convert) ccnt++;
      else if (ccnt != 0) begin
        chk("conv", 18 * 4, ccnt);
        seq.push_back(int'(mux_q));
        gapq.push_back(sample);
        ccnt = 0;
      end
    end
    sq = sar_clk;
    mux_q = mux_sel;
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    rpt(5);
    aresetn <= 1'b1;
    rpt(1);
    rchk(CTRL_OFF, 32'h0);
    rchk(CHAN_EN_OFF, 32'h1);
    rchk(LIMIT_HIGH_OFF, 32'hfff);
    rchk(MASK_OFF, 32'h0);
    rd(8'h3c, d, r);
    chk("rresp", 32'(RESP_SLVERR), 32'(r));
    chk("rdata", 32'h0, d);
    wr(8'h3c, 32'h1, r);
    chk("bresp", 32'(RESP_SLVERR), 32'(r));
    for (int i = 0; i < 4; i++) begin
      wr(CTRL_OFF, 32'(i << 3), r);
      rpt(2);
      chk("ref", 32'(i), 32'(ref_sel));
    end
    // Auto scans: random subset, then all nine channels
    for (int k = 0; k < 2; k++) begin
      en = k ? 9'h1ff : (9'($random(seed)) | 9'h001);
      lo = 12'($random(seed)) & 12'h7ff;
      hi = lo + (12'($random(seed)) & 12'h7ff);
      for (int i = 0; i < 9; i++) begin
        st[i] = 8'($random(seed)) & 8'h07;
        wr(8'h40 + 8'(4 * i), {24'h0, st[i]}, r);
      end
      wr(LIMIT_LOW_OFF, {20'h0, lo}, r);
      wr(LIMIT_HIGH_OFF, {20'h0, hi}, r);
      wr(MASK_OFF, 32'h2, r);
      wr(CHAN_EN_OFF, {23'h0, en}, r);
      seq.delete();
      gapq.delete();
      mon = 1'b1;
      wr(CTRL_OFF, 32'h1, r);
      wr(CMD_OFF, 32'h1, r);
      wirq;
      chk("count", $countones(en), seq.size());
      n = 0;
      any = 1'b0;
      for (int i = 0; i < 9; i++) begin
        if (en[i]) begin
          if (n < seq.size()) chk("order", i, seq[n]);
          if (n < gapq.size() - 1) chk("nogap", 32'h1, 32'(gapq[n]));
          any = any | (res(i) >> 15 != 32'h0);
          n++;
          rchk(8'h80 + 8'(4 * i), res(i));
        end
      end
      rchk(INTR_OFF, {30'h0, 1'b1, any});
      wr(MASK_OFF, 32'h1, r);
      rpt(2);
      chk("irq", 32'(any), 32'(irq));
      wr(INTR_OFF, 32'h3, r);
      rchk(INTR_OFF, 32'h0);
      chk("irq_clr", 32'h0, 32'(irq));
      wr(CTRL_OFF, 32'h0, r);
    end
    // Firmware chosen channel: temperature sensor
    seq.delete();
    wr(MASK_OFF, 32'h2, r);
    wr(CTRL_OFF, 32'h103, r);
    wr(CMD_OFF, 32'h1, r);
    wirq;
    chk("fwchan", 32'h8, seq[0]);
    rchk(8'ha0, res(8));
    wr(INTR_OFF, 32'h3, r);
    // Continuous scan restarts at the lowest channel, then deep low power aborts it
    wr(CTRL_OFF, 32'h5, r);
    wr(CMD_OFF, 32'h1, r);
    wirq;
    chk("cont", 32'h10, {27'h0, sample, mux_sel});
    n = 0;
    while (!sample && n < 20) begin @(posedge aclk); n++; end
    mon = 1'b0;
    lp_deep <= 1'b1;
    rpt(8);
    chk("lp_idle", 32'h0, 32'({sample, convert}));
    rd(STATUS_OFF, d, r);
    chk("lp_flag", 32'h1, 32'(d[5]));
    lp_deep <= 1'b0;
    wr(CTRL_OFF, 32'h0, r);
    summarize;
  end
endmodule
